// [cmbp_host_model.sv]
/*
 Host processor model for the configurable bus port: drives strobes,
 address strobe, address and data per host style, and resolves shared pins.
 Assumes the bench sets style, mux and o_page only between transfers.
*/
`timescale 1ns/100ps
module cmbp_host_model
   import cmbp_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic [15:0] i_adp,
   input wire logic i_adp_oe_n,
   input wire logic [7:0] i_pf,
   input wire logic [7:0] i_pf_oe_n,
   input wire logic [7:0] i_pg,
   input wire logic [7:0] i_pg_oe_n,
   output logic o_c0,
   output logic o_c1,
   output logic o_c2,
   output logic o_hw,
   output logic o_as,
   output logic [15:0] o_adp,
   output logic [7:0] o_pf,
   output logic [7:0] o_pg,
   output logic [3:0] o_page
);
   cmbp_style_t style;
   logic mux;
   logic [15:0] h_adp;
   logic [7:0] h_pf;
   logic [7:0] h_pg;
   logic [15:0] bq [3];

   // Wire level: the device wins where it drives, else the host value
   assign o_adp = i_adp_oe_n ? h_adp : i_adp;
   assign o_pf = (i_pf & ~i_pf_oe_n) | (h_pf & i_pf_oe_n);
   assign o_pg = (i_pg & ~i_pg_oe_n) | (h_pg & i_pg_oe_n);

   // Idle host: strobes high, address strobe low, page 0
   initial begin
      style = CMBP_ST_HBE;
      mux = 1'b1;
      h_adp = 16'h0000;
      h_pf = 8'h00;
      h_pg = 8'h00;
      {o_c0, o_c1, o_c2, o_hw} = 4'hF;
      o_as = 1'b0;
      o_page = 4'h0;
   end

   // One host cycle; be is {upper lane, lower lane}
   task xfer(input logic rd, input logic [5:0] w, input logic [1:0] be,
             input logic [15:0] d, output logic [15:0] q, output logic ok);
      logic moto;
      int n;
      moto = (style == CMBP_ST_SIZ) || (style == CMBP_ST_EB);
      q = 16'h0000;
      n = 0;
      @(posedge i_core_clk);
      // Odd byte has A0 high; only the lane choice differs per style
      // Burst hosts put A19-A4 on the shared bus and A3-A1 on port F
      h_adp <= (style == CMBP_ST_BURST) ? {o_page, 9'h000, w[5:3]}
                                        : {9'h000, w, moto ? (be == 2'b01) : (be == 2'b10)};
      if (style == CMBP_ST_BURST)
         h_pf <= {4'h0, w[2:0], 1'b0};
      if (mux) begin
         o_as <= 1'b1;
         repeat (3) @(posedge i_core_clk);
         o_as <= 1'b0;
         repeat (2) @(posedge i_core_clk);
      end
      // Non-multiplexed: address strobe left idle, address flows
      if (rd && mux)
         h_adp <= ~h_adp;
      else if (mux)
         h_adp <= d;
      else if (!rd)
         {h_pg, h_pf} <= d;
      case (style)
         CMBP_ST_HBE: {o_c0, o_c1, o_c2} <= {rd, !rd, !be[1]};
         CMBP_ST_WRLH, CMBP_ST_BURST:
            {o_c0, o_c1, o_hw} <= {rd | !be[0], !rd, rd | !be[1]};
         CMBP_ST_SIZ: {o_c0, o_c1, o_c2} <= {rd, 1'b0, be != 2'b11};
         default: {o_c0, o_c1, o_c2} <= {rd, !be[1], !be[0]};
      endcase
      // Bounded wait stands in for the host's programmed wait states
      if (rd) begin
         while (((mux ? i_adp_oe_n : i_pf_oe_n[0]) !== 1'b0) && n < 30) begin
            @(posedge i_core_clk);
            n++;
         end
         repeat (2) @(posedge i_core_clk);
         q = mux ? o_adp : {o_pg, o_pf};
      end else begin
         repeat (6) @(posedge i_core_clk);
      end
      ok = (n < 30);
      // Strobes end before levels and data, giving write hold time
      {o_c1, o_hw} <= 2'b11;
      if (!moto)
         o_c0 <= 1'b1;
      if (style == CMBP_ST_EB)
         o_c2 <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      {o_c0, o_c2} <= 2'b11;
      // Released lines float: show the inverse of the last value
      h_adp <= ~h_adp;
      h_pf <= ~h_pf;
      h_pg <= ~h_pg;
      repeat (4) @(posedge i_core_clk);
   endtask

   // Burst fetch: one address strobe, then A3-A1 stepped under a held fetch strobe
   task burst(input logic [5:0] w);
      @(posedge i_core_clk);
      h_adp <= {o_page, 9'h000, w[5:3]};
      h_pf <= {4'h0, w[2:0], 1'b0};
      o_as <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      o_as <= 1'b0;
      repeat (2) @(posedge i_core_clk);
      h_adp <= ~h_adp;
      o_c2 <= 1'b0;
      // No new address strobe between steps
      for (int i = 0; i < 3; i++) begin
         h_pf <= {4'h0, w[2:0] + 3'(i), 1'b0};
         repeat (8) @(posedge i_core_clk);
         bq[i] = o_adp;
      end
      o_c2 <= 1'b1;
      repeat (4) @(posedge i_core_clk);
   endtask
endmodule

// [cmbp_lane_dec.sv]
/*
 Byte lane decoder: turns the three control inputs, the high write input
 and A0 into read, write and lane enables for the selected strobe style.
 Inputs are already synchronised; pure combinational logic.
*/
`timescale 1ns/100ps
module cmbp_lane_dec
   import cmbp_pkg::*;
(
   input wire cmbp_style_t i_style,
   input wire logic i_c0,
   input wire logic i_c1,
   input wire logic i_c2,
   input wire logic i_hw,
   input wire logic i_a0,
   output logic o_rd,
   output logic o_wr,
   output logic o_upper,
   output logic o_lower,
   output logic o_swap,
   output logic o_c2_free
);
   // Strobe decode per style; strobes are active low
   always_comb begin
      o_rd = 1'b0;
      o_wr = 1'b0;
      o_upper = 1'b0;
      o_lower = 1'b0;
      o_swap = 1'b0;
      o_c2_free = 1'b0;
      case (i_style)
         CMBP_ST_HBE: begin
            o_wr = ~i_c0;
            o_rd = ~i_c1;
            o_upper = ~i_c2;
            o_lower = ~i_a0;
         end
         CMBP_ST_WRLH, CMBP_ST_BURST: begin
            o_rd = ~i_c1 | ((i_style == CMBP_ST_BURST) & ~i_c2);
            o_wr = ~i_c0 | ~i_hw;
            // Reads present both lanes; writes use the strobes
            o_upper = o_rd | ~i_hw;
            o_lower = o_rd | ~i_c0;
            o_c2_free = (i_style == CMBP_ST_WRLH);
         end
         CMBP_ST_SIZ: begin
            o_rd = ~i_c1 & i_c0;
            o_wr = ~i_c1 & ~i_c0;
            o_swap = 1'b1;
            o_upper = ~i_a0;
            o_lower = ~i_c2 | i_a0;
         end
         CMBP_ST_EB: begin
            o_rd = (~i_c1 | ~i_c2) & i_c0;
            o_wr = (~i_c1 | ~i_c2) & ~i_c0;
            o_swap = 1'b1;
            o_upper = ~i_c1;
            o_lower = ~i_c2;
         end
         default: begin
            o_rd = 1'b0;
         end
      endcase
   end
endmodule

// [cmbp_mem.sv]
/*
 Internal resource: word memory with byte write enables and registered
 read data. Word layout is {odd byte, even byte}. Single clock.
*/
`timescale 1ns/100ps
module cmbp_mem #(
   parameter int AW = 6
) (
   input wire logic i_core_clk,
   input wire logic [AW-1:0] i_addr,
   input wire logic i_we,
   input wire logic [1:0] i_be,
   input wire logic [15:0] i_wdata,
   output logic [15:0] o_rdata
);
   logic [15:0] mem_ff [0:(1<<AW)-1];

   // Lanes not enabled keep their old byte
   always_ff @(posedge i_core_clk) begin
      if (i_we && i_be[0]) begin
         mem_ff[i_addr][7:0] <= i_wdata[7:0];
      end
      if (i_we && i_be[1]) begin
         mem_ff[i_addr][15:8] <= i_wdata[15:8];
      end
   end

   // Registered read port
   always_ff @(posedge i_core_clk) begin
      o_rdata <= mem_ff[i_addr];
   end
endmodule

// [cmbp_pkg.sv]
/*
 Shared constants for the configurable host bus port: register offsets,
 field positions, reset values and the strobe style codes.
 Assumes a 32-bit AHB-Lite register bus and a 16-bit host bus.
*/
package cmbp_pkg;
   // Register byte offsets
   localparam logic [7:0] CMBP_CFG_OFS = 8'h00;
   localparam logic [7:0] CMBP_STAT_OFS = 8'h04;
   localparam logic [7:0] CMBP_ADDR_OFS = 8'h08;
   // Configuration field positions
   localparam int CMBP_CFG_STYLE_LSB = 0;
   // Mode bits sit above the five one-hot style bits so they never alias
   localparam int CMBP_CFG_MUX_BIT = 5;
   localparam int CMBP_CFG_LATCH_BIT = 6;
   localparam int CMBP_CFG_ASPOL_BIT = 7;
   localparam int CMBP_CFG_PAGE_LSB = 8;
   // Configuration reset: split strobes, multiplexed, strobe active high, page 0
   localparam logic [11:0] CMBP_CFG_RST = 12'h0A1;
   // Host pin sync reset: strobes idle high
   localparam logic [40:0] CMBP_SYNC_RST = 41'h1FF_FFFF_FFFF;
   // Host strobe styles, one-hot
   typedef enum logic [4:0] {
      CMBP_ST_HBE = 5'h01,   // write, read, high byte enable
      CMBP_ST_WRLH = 5'h02,  // low write, read, high write
      CMBP_ST_SIZ = 5'h04,   // read/write level, data strobe, size
      CMBP_ST_BURST = 5'h08, // low/high write, read, program fetch
      CMBP_ST_EB = 5'h10     // read/write level, upper and lower strobes
   } cmbp_style_t;
endpackage

// [cmbp_port.sv]
/*
 Configurable host bus port: synchronises the host pins, latches the
 address, decodes strobes and lanes, and serves an internal word memory.
 Assumes a 50 MHz core clock well above host strobe rates and an
 AHB-Lite master for the configuration registers.
*/
`timescale 1ns/100ps
module cmbp_port
   import cmbp_pkg::*;
#(
   parameter int MEM_AW = 6
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_control_input_0,
   input wire logic i_control_input_1,
   input wire logic i_control_input_2,
   input wire logic i_high_write_input,
   input wire logic i_address_strobe_input,
   input wire logic [15:0] i_address_data_port,
   output logic [15:0] o_address_data_port,
   output logic o_address_data_port_oe_n,
   input wire logic [7:0] i_port_f,
   output logic [7:0] o_port_f,
   output logic [7:0] o_port_f_oe_n,
   input wire logic [7:0] i_port_g,
   output logic [7:0] o_port_g,
   output logic [7:0] o_port_g_oe_n,
   input wire logic [3:0] i_port_a_addr,
   output logic o_spare_logic_input,
   output logic o_spare_logic_valid,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata
);
   logic [40:0] sync1_ff;
   logic [40:0] sync2_ff;
   logic c0, c1, c2, hw, as_pin;
   logic [15:0] ad_bus;
   logic [7:0] pf, pg;
   logic [3:0] pa;
   logic [11:0] cfg_ff;
   cmbp_style_t style;
   logic cfg_mux, cfg_latch, cfg_aspol;
   logic [3:0] cfg_page;
   logic as_act;
   logic [15:0] lat_ff;
   logic [19:0] addr;
   logic rd, wr, upper, lower, swap, c2_free;
   logic sel;
   logic drv_ff;
   logic [15:0] rdata;
   logic [15:0] rlane;
   logic wr_act_ff;
   logic [15:0] wdat_ff;
   logic [MEM_AW-1:0] waddr_ff;
   logic [1:0] wbe_ff;
   logic commit;
   logic [MEM_AW-1:0] maddr;
   logic [15:0] mem_wdata;
   logic [15:0] wcount_ff;
   logic [15:0] rcount_ff;
   logic [1:0] last_lanes_ff;
   logic ph_wr_ff;
   logic [7:0] ph_ofs_ff;
   logic [31:0] nxt_hrdata;

   // Two-stage synchroniser for every host pin
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         sync1_ff <= CMBP_SYNC_RST;
         sync2_ff <= CMBP_SYNC_RST;
      end else begin
         sync1_ff <= {i_control_input_0, i_control_input_1, i_control_input_2,
                      i_high_write_input, i_address_strobe_input, i_address_data_port,
                      i_port_f, i_port_g, i_port_a_addr};
         sync2_ff <= sync1_ff;
      end
   end
   assign {c0, c1, c2, hw, as_pin, ad_bus, pf, pg, pa} = sync2_ff;

   // Configuration fields
   assign style = cmbp_style_t'(cfg_ff[CMBP_CFG_STYLE_LSB +: 5]);
   assign cfg_mux = cfg_ff[CMBP_CFG_MUX_BIT];
   assign cfg_latch = cfg_ff[CMBP_CFG_LATCH_BIT];
   assign cfg_aspol = cfg_ff[CMBP_CFG_ASPOL_BIT];
   assign cfg_page = cfg_ff[CMBP_CFG_PAGE_LSB +: 4];
   assign as_act = (as_pin == cfg_aspol);

   // Address latch is transparent while the strobe is active
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         lat_ff <= 16'h0000;
      end else if (as_act && (cfg_mux || cfg_latch)) begin
         lat_ff <= ad_bus;
      end
   end

   // Address assembly; burst keeps A19-A4 and takes A3-A1 from port F
   always_comb begin
      if (style == CMBP_ST_BURST) begin
         addr = {lat_ff, pf[3:1], 1'b0};
      end else if (cfg_mux || cfg_latch) begin
         addr = {pa, lat_ff};
      end else begin
         addr = {pa, ad_bus};
      end
   end

   cmbp_lane_dec u_dec (
      .i_style(style),
      .i_c0(c0),
      .i_c1(c1),
      .i_c2(c2),
      .i_hw(hw),
      .i_a0(addr[0]),
      .o_rd(rd),
      .o_wr(wr),
      .o_upper(upper),
      .o_lower(lower),
      .o_swap(swap),
      .o_c2_free(c2_free)
   );

   // Page compare on the top address nibble selects the memory
   assign sel = (addr[19:16] == cfg_page);

   // Unused control input 2 handed to the logic array
   assign o_spare_logic_input = c2;
   assign o_spare_logic_valid = c2_free;

   // Drive enable registered so it lines up with read data
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         drv_ff <= 1'b0;
      end else begin
         drv_ff <= sel && rd;
      end
   end

   // Write capture while strobe active, commit on its trailing edge
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         wr_act_ff <= 1'b0;
         wdat_ff <= 16'h0000;
         waddr_ff <= '0;
         wbe_ff <= 2'b00;
      end else begin
         wr_act_ff <= wr && sel;
         if (wr && sel) begin
            wdat_ff <= cfg_mux ? ad_bus : {pg, pf};
            waddr_ff <= addr[MEM_AW:1];
            // Memory byte 1 is odd, byte 0 even
            wbe_ff <= swap ? {lower, upper} : {upper, lower};
         end
      end
   end
   assign commit = wr_act_ff && !(wr && sel);
   assign maddr = commit ? waddr_ff : addr[MEM_AW:1];
   assign mem_wdata = swap ? {wdat_ff[7:0], wdat_ff[15:8]} : wdat_ff;

   cmbp_mem #(
      .AW(MEM_AW)
   ) u_mem (
      .i_core_clk(i_core_clk),
      .i_addr(maddr),
      .i_we(commit),
      .i_be(wbe_ff),
      .i_wdata(mem_wdata),
      .o_rdata(rdata)
   );

   // Read lanes: swapped styles put the even byte on the upper lane
   assign rlane = swap ? {rdata[7:0], rdata[15:8]} : rdata;
   assign o_address_data_port = rlane;
   assign o_address_data_port_oe_n = ~(drv_ff && cfg_mux);
   assign o_port_f = rlane[7:0];
   assign o_port_g = rlane[15:8];
   // Data ports float unless this device answers a non-multiplexed read
   assign o_port_f_oe_n = {8{~(drv_ff && !cfg_mux)}};
   assign o_port_g_oe_n = {8{~(drv_ff && !cfg_mux)}};

   // Access counters and lane record for software
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         wcount_ff <= 16'h0000;
         rcount_ff <= 16'h0000;
         last_lanes_ff <= 2'b00;
      end else begin
         if (commit) begin
            wcount_ff <= wcount_ff + 16'h0001;
            last_lanes_ff <= wbe_ff;
         end
         if (sel && rd && !drv_ff) begin
            rcount_ff <= rcount_ff + 16'h0001;
         end
      end
   end

   // AHB-Lite address phase capture; zero wait states
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         ph_wr_ff <= 1'b0;
         ph_ofs_ff <= 8'h00;
      end else if (hready) begin
         ph_wr_ff <= hsel && htrans[1] && hwrite;
         ph_ofs_ff <= haddr[7:0];
      end
   end

   // Configuration register written in the data phase
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         cfg_ff <= CMBP_CFG_RST;
      end else if (ph_wr_ff && ph_ofs_ff == CMBP_CFG_OFS) begin
         cfg_ff <= hwdata[11:0];
      end
   end

   // Read data prepared during the address phase; unmapped reads zero
   always_comb begin
      nxt_hrdata = 32'h0000_0000;
      case (haddr[7:0])
         CMBP_CFG_OFS: nxt_hrdata = {20'h00000, cfg_ff};
         CMBP_STAT_OFS: nxt_hrdata = {rcount_ff[11:0], wcount_ff[11:0], 5'h00,
                                      last_lanes_ff, drv_ff};
         CMBP_ADDR_OFS: nxt_hrdata = {12'h000, addr};
         default: nxt_hrdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         hrdata <= nxt_hrdata;
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Checks on the host side behaviour
   property p_nonmux_float;
      @(posedge i_core_clk) disable iff (i_rst)
      (!cfg_mux && !$past(sel && rd)) |-> (o_port_f_oe_n == 8'hFF && o_port_g_oe_n == 8'hFF);
   endproperty
   a_nonmux_float: assert property (p_nonmux_float) else $error("data ports driven idle");

   property p_mux_drive;
      @(posedge i_core_clk) disable iff (i_rst)
      !o_address_data_port_oe_n |-> (cfg_mux && $past(sel) && $past(rd));
   endproperty
   a_mux_drive: assert property (p_mux_drive) else $error("mux port driven without read");

   property p_lat_follow;
      @(posedge i_core_clk) disable iff (i_rst)
      (cfg_mux && as_act) |=> (lat_ff == $past(ad_bus));
   endproperty
   a_lat_follow: assert property (p_lat_follow) else $error("address not latched");

   property p_upper_addr;
      @(posedge i_core_clk) disable iff (i_rst)
      (style != CMBP_ST_BURST) |-> (addr[19:16] == pa);
   endproperty
   a_upper_addr: assert property (p_upper_addr) else $error("upper address lost");

   property p_burst_low;
      @(posedge i_core_clk) disable iff (i_rst)
      (style == CMBP_ST_BURST && addr != 20'h00000) |-> (addr[3:1] == pf[3:1]);
   endproperty
   a_burst_low: assert property (p_burst_low) else $error("burst low address wrong");

   property p_hbe_odd;
      @(posedge i_core_clk) disable iff (i_rst)
      (style == CMBP_ST_HBE && !c2 && addr[0]) |-> (upper && !lower);
   endproperty
   a_hbe_odd: assert property (p_hbe_odd) else $error("odd byte lane wrong");

   property p_siz_lower;
      @(posedge i_core_clk) disable iff (i_rst)
      (style == CMBP_ST_SIZ && c2 && addr[0]) |-> (!upper && lower && swap);
   endproperty
   a_siz_lower: assert property (p_siz_lower) else $error("size lane wrong");

   property p_eb_lanes;
      @(posedge i_core_clk) disable iff (i_rst)
      (style == CMBP_ST_EB) |-> (upper == !c1 && lower == !c2);
   endproperty
   a_eb_lanes: assert property (p_eb_lanes) else $error("strobe lane wrong");

   property p_wrlh_high;
      @(posedge i_core_clk) disable iff (i_rst)
      (style == CMBP_ST_WRLH && !hw && c0 && c1) |-> (wr && upper && !lower);
   endproperty
   a_wrlh_high: assert property (p_wrlh_high) else $error("high write lane wrong");

   property p_commit_be;
      @(posedge i_core_clk) disable iff (i_rst)
      commit |-> (wbe_ff != 2'b00 && wr_act_ff && $past(wr && sel));
   endproperty
   a_commit_be: assert property (p_commit_be) else $error("commit without lanes");

   property p_spare;
      @(posedge i_core_clk) disable iff (i_rst)
      (style == CMBP_ST_WRLH) |-> (o_spare_logic_valid && o_spare_logic_input == c2);
   endproperty
   a_spare: assert property (p_spare) else $error("spare input not offered");

   c_read_nonmux: cover property (@(posedge i_core_clk) disable iff (i_rst)
      !cfg_mux && o_port_f_oe_n == 8'h00);
   c_read_mux: cover property (@(posedge i_core_clk) disable iff (i_rst)
      !o_address_data_port_oe_n);
   c_write: cover property (@(posedge i_core_clk) disable iff (i_rst) commit);
endmodule

// [tb_configurable_mcu_bus_port.sv]
/*
 Self-checking bench for the host bus port: AHB-Lite register access and
 host cycles in five strobe styles against a byte-lane memory model.
 Assumes the host model file is compiled before this one.
*/
`timescale 1ns/100ps
module tb_configurable_mcu_bus_port
   import cmbp_pkg::*;
;
   logic i_core_clk, i_rst, c0, c1, c2, hw, as_s, adp_oe_n, spare, spare_v;
   logic [15:0] adp_w, adp_o;
   logic [7:0] pf_w, pf_o, pf_oe_n, pg_w, pg_o, pg_oe_n;
   logic [3:0] page;
   logic hsel, hwrite, hready, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   int mismatches = 0;
   int compares = 0;
   logic [31:0] lfsr_s = 32'h5903;
   logic [15:0] ref_mem [64];
   logic moto;

   cmbp_port #(.MEM_AW(6)) u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
      .i_control_input_0(c0), .i_control_input_1(c1), .i_control_input_2(c2),
      .i_high_write_input(hw), .i_address_strobe_input(as_s),
      .i_address_data_port(adp_w), .o_address_data_port(adp_o),
      .o_address_data_port_oe_n(adp_oe_n), .i_port_f(pf_w), .o_port_f(pf_o),
      .o_port_f_oe_n(pf_oe_n), .i_port_g(pg_w), .o_port_g(pg_o), .o_port_g_oe_n(pg_oe_n),
      .i_port_a_addr(page), .o_spare_logic_input(spare), .o_spare_logic_valid(spare_v),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata));

   cmbp_host_model u_host (.i_core_clk(i_core_clk), .i_adp(adp_o), .i_adp_oe_n(adp_oe_n),
      .i_pf(pf_o), .i_pf_oe_n(pf_oe_n), .i_pg(pg_o), .i_pg_oe_n(pg_oe_n), .o_c0(c0),
      .o_c1(c1), .o_c2(c2), .o_hw(hw), .o_as(as_s), .o_adp(adp_w), .o_pf(pf_w),
      .o_pg(pg_w), .o_page(page));

   // Free-running 50 MHz clock
   initial begin
      i_core_clk = 1'b0;
      forever #10 i_core_clk = ~i_core_clk;
   end

   function logic [15:0] rnd();
      lfsr_s = {lfsr_s[30:0], lfsr_s[31] ^ lfsr_s[21] ^ lfsr_s[1] ^ lfsr_s[0]};
      return lfsr_s[15:0];
   endfunction

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h got %h", nm, e, g);
      end
   endtask

   task summarize();
      $display("Counts: compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Single word transfer; waits on hready, read data taken at data-phase end
   task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] q);
      @(posedge i_core_clk);
      {hsel, htrans, hwrite} <= {1'b1, 2'b10, wr};
      haddr <= a;
      do @(posedge i_core_clk); while (hready !== 1'b1);
      {hsel, htrans} <= 3'b000;
      hwdata <= d;
      do @(posedge i_core_clk); while (hready !== 1'b1);
      q = hrdata;
   endtask

   // Host write, then the reference takes only enabled lanes
   task host_wr(input logic [5:0] w, input logic [1:0] be, input logic [15:0] d);
      logic [15:0] q;
      logic ok;
      logic [15:0] wd;
      logic [1:0] bb;
      u_host.xfer(1'b0, w, be, d, q, ok);
      wd = moto ? {d[7:0], d[15:8]} : d;
      bb = moto ? {be[0], be[1]} : be;
      if (bb[1])
         ref_mem[w][15:8] = wd[15:8];
      if (bb[0])
         ref_mem[w][7:0] = wd[7:0];
   endtask

   task host_rd(input logic [5:0] w);
      logic [15:0] q;
      logic ok;
      u_host.xfer(1'b1, w, 2'b11, 16'h0000, q, ok);
      chk("read_drive", 32'h1, {31'h0, ok});
      chk("read_data", {16'h0, moto ? {ref_mem[w][7:0], ref_mem[w][15:8]} : ref_mem[w]},
          {16'h0, q});
   endtask

   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge i_core_clk);
      mismatches++;
      summarize();
   end

   // Main sequence
   initial begin
      logic [31:0] q;
      logic [31:0] cfgv [5];
      cmbp_style_t sty [5];
      logic [5:0] w;
      cfgv = '{32'h0A1, 32'h002, 32'h004, 32'h010, 32'h0A8};
      sty = '{CMBP_ST_HBE, CMBP_ST_WRLH, CMBP_ST_SIZ, CMBP_ST_EB, CMBP_ST_BURST};
      {i_rst, hsel, hwrite, htrans, hsize} = {3'b100, 2'b00, 3'b010};
      haddr = 32'h0;
      hwdata = 32'h0;
      repeat (5) @(posedge i_core_clk);
      i_rst <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      ahb(1'b0, {24'h0, CMBP_CFG_OFS}, 32'h0, q);
      chk("cfg_reset", {20'h0, CMBP_CFG_RST}, q);
      chk("hresp", 32'h0, {31'h0, hresp});
      ahb(1'b0, 32'h0000_000C, 32'h0, q);
      chk("unmapped_read", 32'h0, q);
      $display("Test reset done");
      for (int s = 0; s < 5; s++) begin
         ahb(1'b1, {24'h0, CMBP_CFG_OFS}, cfgv[s], q);
         ahb(1'b0, {24'h0, CMBP_CFG_OFS}, 32'h0, q);
         chk("cfg_write", cfgv[s], q);
         u_host.style = sty[s];
         u_host.mux = cfgv[s][CMBP_CFG_MUX_BIT];
         moto = (sty[s] == CMBP_ST_SIZ) || (sty[s] == CMBP_ST_EB);
         for (int k = 0; k < 3; k++) begin
            w = 6'(s * 8 + k);
            host_wr(w, 2'b11, rnd());
            host_rd(w);
            host_wr(w, 2'b10, rnd());
            host_wr(w, 2'b01, rnd());
            host_rd(w);
         end
         // Burst fetch of the three words just written
         if (sty[s] == CMBP_ST_BURST) begin
            u_host.burst(w - 6'd2);
            for (int i = 0; i < 3; i++) begin
               chk("burst_data", {16'h0, ref_mem[w - 6'd2 + 6'(i)]},
                   {16'h0, u_host.bq[i]});
            end
         end
         // Foreign page: the write must not land
         u_host.o_page <= 4'h1;
         u_host.xfer(1'b0, w, 2'b11, ~ref_mem[w], q[15:0], q[16]);
         u_host.o_page <= 4'h0;
         host_rd(w);
         chk("idle_oe", 32'h1FFFF, {15'h0, adp_oe_n, pf_oe_n, pg_oe_n});
         chk("spare_valid", {31'h0, sty[s] == CMBP_ST_WRLH}, {31'h0, spare_v});
         chk("spare_input", 32'h1, {31'h0, spare});
         $display("Test style %0d done", s);
      end
      summarize();
   end
endmodule
